// >>> bench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  output logic o_scl,
  input wire logic i_sda,
  output logic o_sda_pull
);
  // Quarter of the 125 ns bus clock, free of the system clock phase
  localparam realtime QTR = 31.25;

  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // ----------------------------------------
  // Bit level
  // ----------------------------------------
  // change data while the clock is low
  task automatic clk_bit(input logic pull_low, output logic smp);
    #QTR o_sda_pull = pull_low;
    #QTR o_scl = 1'b1;
    #QTR smp = i_sda;
    #QTR o_scl = 1'b0;
  endtask

  // start also serves as repeated start
  task automatic start();
    #QTR o_sda_pull = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_pull = 1'b1;
    #QTR o_scl = 1'b0;
  endtask

  task automatic stop();
    #QTR o_sda_pull = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_pull = 1'b0;
    #QTR;
  endtask

  // ----------------------------------------
  // Byte level
  // ----------------------------------------
  // bytes go out most significant bit first
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], smp);
    end
    clk_bit(1'b0, ack);
  endtask

  // master acks to continue, releases to end the read
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, b[i]);
    end
    clk_bit(more, smp);
  endtask
endmodule // i2c_master_model

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import dpot_pkg::*;
  localparam int NV_CYC = 2000;
  logic i_clk_sys, i_rst, shutdown_request_n, strap_hi, strap_lo, scl, pull, sda_o, sda_oe, make_en, hi_open, w_low, ack;
  wire sda_w;
  logic [6:0] tap_sel, tap_make, wiper, initial_wiper_value, nv_pend;
  logic volatile_select, shutdown_request, busy;
  logic [7:0] rd;
  logic [31:0] seed;
  int err_count, samples_checked;

  // Open drain data line with pull-up
  assign sda_w = ~(pull | sda_oe);

  dpot_ctrl #(.NV_WRITE_CYCLES_P(NV_CYC)) dpot_ctrl_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1), .i_scl(scl), .i_sda(sda_w),
    .i_shutdown_request_n(shutdown_request_n), .i_addr_strap_hi(strap_hi), .i_addr_strap_lo(strap_lo),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_tap_sel(tap_sel), .o_tap_make(tap_make),
    .o_tap_make_en(make_en), .o_high_terminal_open(hi_open), .o_wiper_to_low(w_low)
  );

  i2c_master_model i2c_master_model_inst (.o_scl(scl), .i_sda(sda_w), .o_sda_pull(pull));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------
  // Helpers and checks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] addr);
    if (addr == 8'h00) return {1'b0, (volatile_select ? wiper : initial_wiper_value)};
    if (addr == 8'h02) return {volatile_select, shutdown_request, busy, 5'h00};
    return 8'h00;
  endfunction

  task automatic chk_pot();
    chk_val({1'b0, tap_sel}, {1'b0, wiper});
    chk_val({1'b0, tap_make}, {1'b0, wiper});
    chk_flag(make_en, 1'b0);
    chk_flag(sda_o, 1'b0);
    chk_flag(sda_oe, 1'b0);
    chk_flag(hi_open, ~shutdown_request | ~shutdown_request_n);
    chk_flag(w_low, ~shutdown_request | ~shutdown_request_n);
  endtask

  task automatic send_hdr(input logic [7:0] addr);
    i2c_master_model_inst.start();
    i2c_master_model_inst.wr_byte({5'b01010, strap_hi, strap_lo, 1'b0}, ack);
    chk_flag(ack, 1'b0);
    i2c_master_model_inst.wr_byte(addr, ack);
    chk_flag(ack, 1'b0);
  endtask

  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    send_hdr(addr);
    i2c_master_model_inst.wr_byte(data, ack);
    chk_flag(ack, 1'b0);
    i2c_master_model_inst.stop();
    if (!busy && addr == 8'h00) begin
      wiper = data[6:0];
      if (!volatile_select) begin
        nv_pend = data[6:0];
        busy = 1'b1;
      end
    end else if (!busy && addr == 8'h02) begin
      volatile_select = data[7];
      shutdown_request = data[6];
    end
    cyc(6);
    chk_pot();
  endtask

  task automatic reg_rd(input logic [7:0] addr);
    send_hdr(addr);
    i2c_master_model_inst.start();
    i2c_master_model_inst.wr_byte({5'b01010, strap_hi, strap_lo, 1'b1}, ack);
    chk_flag(ack, 1'b0);
    i2c_master_model_inst.rd_byte(1'b1, rd);
    chk_val(rd, exp_rd(addr));
    i2c_master_model_inst.rd_byte(1'b0, rd);
    chk_val(rd, exp_rd(addr));
    i2c_master_model_inst.stop();
  endtask

  task automatic do_reset();
    i_rst = 1'b1;
    cyc(8);
    i_rst = 1'b0;
    {volatile_select, shutdown_request, busy} = 3'b010;
    wiper = 7'h40;
    cyc(1);
    chk_pot();
    cyc(120);
    wiper = initial_wiper_value;
    chk_pot();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    samples_checked = 0;
    seed = 32'h93A33E57;
    i_rst = 1'b1;
    shutdown_request_n = 1'b1;
    {strap_hi, strap_lo} = seed[1:0];
    initial_wiper_value = NV_BLANK;
    nv_pend = 7'h00;
    do_reset();
    reg_rd(ADDR_ACCESS);
    reg_wr(ADDR_ACCESS, 8'hDF);
    reg_rd(ADDR_ACCESS);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      reg_wr(ADDR_WIPER, (i == 0) ? 8'h7F : (i == 1) ? 8'h00 : {1'b0, seed[6:0]});
      reg_rd(ADDR_WIPER);
    end
    reg_wr(8'h01, 8'h55);
    reg_rd(8'h01);
    reg_rd(8'h03);
    i2c_master_model_inst.start();
    i2c_master_model_inst.wr_byte({5'b01010, strap_hi, ~strap_lo, 1'b0}, ack);
    chk_flag(ack, 1'b1);
    i2c_master_model_inst.stop();
    reg_wr(ADDR_ACCESS, 8'h80);
    reg_wr(ADDR_WIPER, 8'h15);
    reg_rd(ADDR_WIPER);
    reg_wr(ADDR_ACCESS, 8'hC0);
    shutdown_request_n = 1'b0;
    cyc(6);
    chk_pot();
    shutdown_request_n = 1'b1;
    cyc(6);
    chk_pot();
    reg_wr(ADDR_ACCESS, 8'h40);
    seed = lfsr(seed);
    reg_wr(ADDR_WIPER, {1'b0, seed[6:0]});
    reg_rd(ADDR_ACCESS);
    reg_wr(ADDR_WIPER, 8'h11);
    reg_wr(ADDR_ACCESS, 8'hC0);
    cyc(NV_CYC + 10);
    busy = 1'b0;
    initial_wiper_value = nv_pend;
    reg_rd(ADDR_ACCESS);
    reg_rd(ADDR_WIPER);
    do_reset();
    reg_rd(ADDR_WIPER);
    test_done();
  end

  initial begin
    #600000;
    err_count++;
    test_done();
  end
endmodule // testbench

`default_nettype wire

// >>> core/dpot_ctrl.sv
// What this block does
// - Code 127 puts the wiper nearest the high terminal, 0 nearest low.
// - Seven-bit wiper; codes 00h to 7Fh step monotonically low to high.
// - Tap changes connect the new tap before releasing the old one.
// - Wiper presets to 40h at power-up, then reloads from retained value.
// - Retained initial value survives power-down and is copied to the wiper.
// - Shutdown opens the high end and ties the wiper to the low terminal.
// - Leaving shutdown restores the wiper from its unchanged register.
// - Shutdown when the pin is low or the shutdown bit is zero.
// - Shutdown bit six resets to one; writing zero enters shutdown.
// - Serial access and all registers keep working during shutdown.
// - Data bits are sampled on clock rise and changed after clock fall.
// - Data line is only pulled low or released, never driven high.
// - The two straps are the low slave address bits; the upper five must match 01010.
// - Address 0 holds initial value and wiper, 1 reserved, 2 access control.
// - Volatile select bit seven resets to zero and steers address 0.
// - Writing the initial value also writes the same value to the wiper.
// - Bit five reads one while a retained write is in progress.
// - Writes to wiper and access control are ignored while writing.
// - Identification byte is 01010, strap hi, strap lo, then read flag.
// - Write is start, id, address, data, stop; all three bytes acked.
// - Reads continue while the master acks; nack and stop end them.
// - The retained write starts after stop and may take 20 ms.
`timescale 1ns/1ps
`default_nettype none

module dpot_ctrl #(
  parameter int unsigned NV_WRITE_CYCLES_P = dpot_pkg::NV_WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_shutdown_request_n,
  input wire logic i_addr_strap_hi,
  input wire logic i_addr_strap_lo,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic [6:0] o_tap_sel,
  output logic [6:0] o_tap_make,
  output logic o_tap_make_en,
  output logic o_high_terminal_open,
  output logic o_wiper_to_low
);
  import dpot_pkg::*;
  localparam logic [21:0] WIP_LAST = 22'(NV_WRITE_CYCLES_P - 1);
  pins_t pins_raw, pins_s;
  bus_evt_t evt;
  slave_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, reg_addr_r, rd_byte, boot_cnt_r;
  logic is_read_r, mack_r, wr_pulse_r, stop_pulse_r;
  logic [6:0] wiper_r, nv_pend_r, id_match;
  logic [6:0] nv_store_r = NV_BLANK;
  logic nv_arm_r, vol_r, shutdown_request_bit_r, wip_r, booting_r, nv_done, shut_req;
  logic [21:0] wip_cnt_r;
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  assign pins_raw = {i_scl, i_sda, i_shutdown_request_n, i_addr_strap_hi, i_addr_strap_lo};
  dpot_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_pins(pins_raw),
    .o_pins(pins_s),
    .o_evt(evt)
  );
  assign id_match = {ID_PREFIX, pins_s.strap_hi, pins_s.strap_lo};

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (reg_addr_r == ADDR_WIPER) begin
      rd_byte = {1'h0, (vol_r ? wiper_r : nv_store_r)};
    end else if (reg_addr_r == ADDR_ACCESS) begin
      rd_byte = {vol_r, shutdown_request_bit_r, wip_r, 5'h00};
    end
  end

  // ----------------------------------------
  // Serial slave state machine
  // ----------------------------------------
  // bus works in shutdown
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      reg_addr_r <= 8'h00;
      is_read_r <= 1'h0;
      mack_r <= 1'h0;
      wr_pulse_r <= 1'h0;
      stop_pulse_r <= 1'h0;
      o_sda_oe <= 1'h0;
      o_sda_o <= 1'h0;
    end else if (i_ce) begin
      wr_pulse_r <= 1'h0;
      stop_pulse_r <= 1'h0;
      if (booting_r) begin
        // Start conditions are ignored while powering up
        state_r <= ST_IDLE;
        o_sda_oe <= 1'h0;
      end else if (evt.start) begin
        state_r <= ST_ID;
        bit_cnt_r <= 4'h0;
        o_sda_oe <= 1'h0;
      end else if (evt.stop) begin
        state_r <= ST_IDLE;
        o_sda_oe <= 1'h0;
        stop_pulse_r <= 1'h1;
      end else begin
        case (state_r)
          ST_ID: begin
            if (evt.scl_rise) begin
              shift_r <= {shift_r[6:0], evt.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (evt.scl_fall && bit_cnt_r == BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              if (shift_r[7:1] == id_match) begin
                o_sda_oe <= 1'h1;
                is_read_r <= shift_r[0];
                state_r <= ST_ID_ACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_ID_ACK: begin
            if (evt.scl_fall) begin
              if (is_read_r) begin
                shift_r <= rd_byte;
                o_sda_oe <= ~rd_byte[7];
                state_r <= ST_RDATA;
              end else begin
                o_sda_oe <= 1'h0;
                state_r <= ST_REG;
              end
            end
          end
          ST_REG: begin
            if (evt.scl_rise) begin
              shift_r <= {shift_r[6:0], evt.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (evt.scl_fall && bit_cnt_r == BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              reg_addr_r <= shift_r;
              o_sda_oe <= 1'h1;
              state_r <= ST_REG_ACK;
            end
          end
          ST_REG_ACK: begin
            if (evt.scl_fall) begin
              o_sda_oe <= 1'h0;
              state_r <= ST_WDATA;
            end
          end
          ST_WDATA: begin
            if (evt.scl_rise) begin
              shift_r <= {shift_r[6:0], evt.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (evt.scl_fall && bit_cnt_r == BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              o_sda_oe <= 1'h1;
              wr_pulse_r <= 1'h1;
              state_r <= ST_WDATA_ACK;
            end
          end
          ST_WDATA_ACK: begin
            // Further bytes of this frame are not acknowledged
            if (evt.scl_fall) begin
              o_sda_oe <= 1'h0;
              state_r <= ST_IDLE;
            end
          end
          ST_RDATA: begin
            if (evt.scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (evt.scl_fall) begin
              if (bit_cnt_r == BYTE_BITS) begin
                bit_cnt_r <= 4'h0;
                o_sda_oe <= 1'h0;
                state_r <= ST_RACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'h0};
                o_sda_oe <= ~shift_r[6];
              end
            end
          end
          ST_RACK: begin
            if (evt.scl_rise) begin
              mack_r <= ~evt.sda;
            end else if (evt.scl_fall) begin
              if (mack_r) begin
                shift_r <= rd_byte;
                o_sda_oe <= ~rd_byte[7];
                state_r <= ST_RDATA;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
            o_sda_oe <= 1'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers, recall and retained write
  // ----------------------------------------
  assign nv_done = wip_r && (wip_cnt_r == WIP_LAST);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wiper_r <= WIPER_PRESET;
      vol_r <= VOL_RESET;
      shutdown_request_bit_r <= SHUTDOWN_REQUEST_RESET;
      nv_pend_r <= 7'h00;
      nv_arm_r <= 1'h0;
      wip_r <= 1'h0;
      wip_cnt_r <= 22'h000000;
      booting_r <= 1'h1;
      boot_cnt_r <= 8'h00;
    end else if (i_ce) begin
      if (booting_r) begin
        if (boot_cnt_r == BOOT_LAST) begin
          booting_r <= 1'h0;
          wiper_r <= nv_store_r;
        end else begin
          boot_cnt_r <= boot_cnt_r + 8'h01;
        end
      end else begin
        if (wr_pulse_r && !wip_r) begin
          if (reg_addr_r == ADDR_WIPER) begin
            wiper_r <= shift_r[6:0];
            if (!vol_r) begin
              nv_pend_r <= shift_r[6:0];
              nv_arm_r <= 1'h1;
            end
          end else if (reg_addr_r == ADDR_ACCESS) begin
            vol_r <= shift_r[VOL_BIT];
            shutdown_request_bit_r <= shift_r[SHUTDOWN_REQUEST_BIT];
          end
        end
        if (stop_pulse_r && nv_arm_r) begin
          wip_r <= 1'h1;
          nv_arm_r <= 1'h0;
          wip_cnt_r <= 22'h000000;
        end else if (nv_done) begin
          wip_r <= 1'h0;
        end else if (wip_r) begin
          wip_cnt_r <= wip_cnt_r + 22'h000001;
        end
      end
    end
  end
  // Retained store survives reset, which stands for power loss
  always_ff @(posedge i_clk_sys) begin
    if (i_ce && nv_done) begin
      nv_store_r <= nv_pend_r;
    end
  end

  // ----------------------------------------
  // Shutdown and tap switching
  // ----------------------------------------
  // pin and bit combined
  assign shut_req = ~pins_s.shutdown_request_n | ~shutdown_request_bit_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_high_terminal_open <= 1'h0;
      o_wiper_to_low <= 1'h0;
      o_tap_sel <= WIPER_PRESET;
      o_tap_make <= WIPER_PRESET;
      o_tap_make_en <= 1'h0;
    end else if (i_ce) begin
      o_high_terminal_open <= shut_req;
      o_wiper_to_low <= shut_req;
      if (o_tap_make_en) begin
        o_tap_sel <= o_tap_make;
        o_tap_make_en <= 1'h0;
      end else if (wiper_r != o_tap_sel) begin
        o_tap_make <= wiper_r;
        o_tap_make_en <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sda_low_only_a: assert property (o_sda_o == 1'h0)
    else $error("data line driven high");
  sda_fall_change_a: assert property ($rose(o_sda_oe) |-> $past(evt.scl_fall))
    else $error("data pulled low without clock fall");
  make_break_a: assert property (
    !$past(i_rst) && $changed(o_tap_sel) |-> $past(o_tap_make_en) && $past(o_tap_make) == o_tap_sel)
    else $error("tap released before new tap made");
  tap_follow_a: assert property (
    i_ce && !o_tap_make_en && wiper_r != o_tap_sel ##1 i_ce |=> o_tap_sel == $past(wiper_r, 2))
    else $error("tap does not reach wiper code");
  shutdown_combine_a: assert property (
    i_ce && shut_req |=> o_wiper_to_low && o_high_terminal_open)
    else $error("shutdown request not applied");
  wiper_preset_a: assert property ($past(i_rst) |-> wiper_r == WIPER_PRESET)
    else $error("wiper not preset after reset");
  access_reset_a: assert property ($past(i_rst) |-> shutdown_request_bit_r && !vol_r)
    else $error("access control reset value wrong");
  boot_recall_a: assert property (
    i_ce && booting_r && boot_cnt_r == BOOT_LAST |=> wiper_r == $past(nv_store_r) && !booting_r)
    else $error("retained value not recalled");
  id_mismatch_a: assert property (
    i_ce && !booting_r && !evt.stop && state_r == ST_ID && evt.scl_fall && bit_cnt_r == BYTE_BITS
    && shift_r[7:1] != id_match |=> state_r == ST_IDLE && !o_sda_oe)
    else $error("foreign address acknowledged");
  ivr_to_wiper_a: assert property (
    i_ce && !booting_r && wr_pulse_r && !wip_r && !vol_r && reg_addr_r == ADDR_WIPER
    |=> wiper_r == $past(shift_r[6:0]) && nv_arm_r)
    else $error("initial value write missed wiper");
  busy_blocks_a: assert property (
    i_ce && !booting_r && wr_pulse_r && wip_r |=> $stable(wiper_r) && $stable(vol_r) && $stable(shutdown_request_bit_r))
    else $error("write taken while busy");
  busy_window_a: assert property (
    i_ce && !booting_r && stop_pulse_r && nv_arm_r |=> wip_r && wip_cnt_r == 22'h000000)
    else $error("retained write did not start after stop");
  low_bits_zero_a: assert property (reg_addr_r == ADDR_ACCESS |-> rd_byte[4:0] == 5'h00)
    else $error("reserved access bits nonzero");
  ivr_write_c: cover property (wr_pulse_r && !vol_r && reg_addr_r == ADDR_WIPER);
  read_acked_c: cover property (state_r == ST_RACK && evt.scl_fall && mack_r);
  busy_set_c: cover property ($rose(wip_r));
  shutdown_c: cover property ($rose(o_wiper_to_low));

endmodule // dpot_ctrl

`default_nettype wire

// >>> core/dpot_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dpot_pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire dpot_pkg::pins_t i_pins,
  output dpot_pkg::pins_t o_pins,
  output dpot_pkg::bus_evt_t o_evt
);
  import dpot_pkg::*;

  pins_t meta_r;
  pins_t sync_r;
  pins_t prev_r;

  // ----------------------------------------
  // Two-stage synchroniser plus history
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_r <= PINS_IDLE;
      sync_r <= PINS_IDLE;
      prev_r <= PINS_IDLE;
    end else if (i_ce) begin
      meta_r <= i_pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ----------------------------------------
  // Edge and bus condition detection
  // ----------------------------------------
  always_comb begin
    o_evt.scl_rise = sync_r.scl & ~prev_r.scl;
    o_evt.scl_fall = ~sync_r.scl & prev_r.scl;
    o_evt.start = sync_r.scl & prev_r.scl & prev_r.sda & ~sync_r.sda;
    o_evt.stop = sync_r.scl & prev_r.scl & ~prev_r.sda & sync_r.sda;
    o_evt.sda = sync_r.sda;
  end

  assign o_pins = sync_r;

endmodule // dpot_pin_sync

`default_nettype wire

// >>> core/dpot_pkg.sv
`default_nettype none

package dpot_pkg;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] ADDR_WIPER = 8'h00;
  localparam logic [7:0] ADDR_ACCESS = 8'h02;
  localparam int VOL_BIT = 7;
  localparam int SHUTDOWN_REQUEST_BIT = 6;
  localparam int WIP_BIT = 5;
  localparam logic [6:0] WIPER_PRESET = 7'h40;
  // Content of the retained store before its first write, arbitrary
  localparam logic [6:0] NV_BLANK = 7'h40;
  localparam logic VOL_RESET = 1'h0;
  localparam logic SHUTDOWN_REQUEST_RESET = 1'h1;

  // ----------------------------------------
  // Serial bus
  // ----------------------------------------
  localparam logic [4:0] ID_PREFIX = 5'h0A;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NV_WRITE_MS = 20;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int NV_READY_NS = 1000;
  localparam int NV_READY_CYCLES = NV_READY_NS / CLK_PERIOD_NS;
  localparam logic [7:0] BOOT_LAST = 8'(NV_READY_CYCLES - 1);

  // ----------------------------------------
  // Carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
    logic shutdown_request_n;
    logic strap_hi;
    logic strap_lo;
  } pins_t;

  localparam pins_t PINS_IDLE = 5'h1F;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } bus_evt_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ID = 9'h002,
    ST_ID_ACK = 9'h004,
    ST_REG = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } slave_state_t;

endpackage

`default_nettype wire
